/* isu_pkg.sv */
// Package of constants for the interrupt status and side-pin unit.
// Assumes an 8-bit register port driven by a serial-interface front end on REF_CLK.
package isu_pkg;
   // ********************************
   // Register offsets
   // ********************************
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h22;
   localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h23;
   localparam logic [7:0] ADDR_LIVE_FLAGS = 8'h24;
   localparam logic [7:0] ADDR_AUX_CONFIG = 8'h25;
   localparam logic [7:0] ADDR_AUX_SELECTS = 8'h26;
   localparam logic [7:0] ADDR_RESET_KEY = 8'h3f;
   // ********************************
   // Values and fields
   // ********************************
   localparam logic [7:0] RESET_KEY_VALUE = 8'hde;
   localparam logic [7:0] IRQ_MASK_RESET = 8'h08;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [3:0] HOOKUP_SIDE_A = 4'h1;
   localparam logic [3:0] HOOKUP_SIDE_B = 4'h2;
   localparam logic [3:0] HOOKUP_SIDE_C = 4'h3;
   localparam logic [3:0] SEL_STATUS_BASE = 4'h8;
   localparam logic [3:0] SEL_STATUS_LAST = 4'hb;
   localparam int BIT_SHORT = 7;
   localparam int BIT_RESET_SEEN = 6;
   localparam int BIT_NEAR = 6;
   localparam int BIT_PRESENCE = 5;
   localparam int BIT_CAL = 4;
   localparam int BIT_SAMPLING = 3;
   localparam int BIT_STYLUS_DOWN = 3;
   localparam int BIT_STYLUS_UP = 2;
   localparam int BIT_WARN = 1;
   localparam int BIT_ALARM = 0;
   localparam int EN_PIN_A = 6;
   localparam int EN_PIN_B = 5;
   localparam int EN_PIN_C = 4;
endpackage

/* isu_sync.sv */
// Two-stage synchroniser for a bus of pin-level inputs.
// Assumes inputs are quasi-static levels from outside the REF_CLK domain.
`timescale 1ns/1ps
module isu_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clk, // Sampling clock
   input wire logic rst_n, // Async reset, low
   input wire logic ce, // Clock enable
   input wire logic [WIDTH-1:0] d, // Asynchronous levels
   output logic [WIDTH-1:0] q // Synchronised levels
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_q;

   // First stage feeds only the second stage
   always_comb begin
      next_meta = ce ? d : meta;
      next_q = ce ? meta : q;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= next_meta;
         q <= next_q;
      end
   end
endmodule

/* isu_pin_mux.sv */
// Side-pin source selector: one registered output bit and its drive enable.
// Assumes selector and gating are registered upstream on the same clock.
`timescale 1ns/1ps
module isu_pin_mux (
   input wire logic clk, // System clock
   input wire logic rst_n, // Async reset, low
   input wire logic ce, // Clock enable
   input wire logic [3:0] sel, // Source select code
   input wire logic [7:0] events, // Event flags
   input wire logic [7:0] live, // Live flags
   input wire logic drive_en, // Configured enable
   input wire logic blocked, // Pin taken by another use
   output logic pin_o, // Pin level
   output logic pin_oe // Pin drive enable
);
   logic next_pin_o;
   logic next_pin_oe;

   // Codes past the status range read as zero
   always_comb begin
      next_pin_o = pin_o;
      next_pin_oe = pin_oe;
      if (ce) begin
         if (!sel[3]) begin
            next_pin_o = events[sel[2:0]];
         end else if (sel <= isu_pkg::SEL_STATUS_LAST) begin
            next_pin_o = live[sel[1:0]];
         end else begin
            next_pin_o = 1'b0;
         end
         next_pin_oe = drive_en && !blocked;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_o <= 1'b0;
         pin_oe <= 1'b0;
      end else begin
         pin_o <= next_pin_o;
         pin_oe <= next_pin_oe;
      end
   end
endmodule

/* isu_top.sv */
// Interrupt sources, live status, side-pin routing and keyed soft reset.
// Assumes a same-clock register port (strobes one cycle) from the serial front end,
// and sensing inputs arriving asynchronously from the analog/sequencer side.
`timescale 1ns/1ps
module isu_top (
   input wire logic REF_CLK, // System clock 125 MHz
   input wire logic RESETN, // Async reset, low
   input wire logic CE, // Clock enable, freezes state when low
   input wire logic [7:0] REG_ADDR, // Register address
   input wire logic [7:0] REG_WDATA, // Write data
   input wire logic REG_WR, // Write strobe, one cycle
   input wire logic REG_RD, // Read strobe, one cycle
   output logic [7:0] REG_RDATA, // Read data, valid cycle after strobe
   input wire logic MOTOR_SHORT_LIVE, // Haptics short present (async)
   input wire logic OBJECT_NEAR_RAW, // Proximity close from sensing (async)
   input wire logic [7:0] PRESENCE_AVERAGE_RAW, // Averaged proximity value
   input wire logic CALIBRATION_BUSY, // Calibration executing (async)
   input wire logic SAMPLING_ACTIVE_FLAG, // Any conversion running (async)
   input wire logic PRESENCE_SAMPLE_KIND, // 1 when running conversion is proximity
   input wire logic STYLUS_DOWN_LIVE, // Pen down (async)
   input wire logic HEAT_WARNING_LIVE, // Above warning threshold (async)
   input wire logic HEAT_ALARM_LIVE, // Above alarm threshold (async)
   input wire logic PRESENCE_EVENT_CHOICE, // 1 selects sample done for bit 5
   input wire logic HEAT_WARNING_EDGE_CHOICE, // 1 selects falling edge
   input wire logic HEAT_ALARM_EDGE_CHOICE, // 1 selects falling edge
   input wire logic STYLUS_DETECT_MODE, // Pen-detect mode active
   input wire logic PANEL_WIRING_TYPE, // Touchscreen type setting
   input wire logic [3:0] PRESENCE_SENSOR_HOOKUP, // Sensor connection field
   input wire logic [3:0] PRESENCE_SHIELD_HOOKUP, // Shield connection field
   output logic IRQ, // Host interrupt, high active
   output logic CALIBRATION_REQUEST, // One-cycle compensation request
   output logic SOFT_RESET_PULSE, // One-cycle chip reset request
   output logic [7:0] PRESENCE_AVERAGE_VALUE, // Held averaged proximity
   output logic SIDE_PIN_A_O, // Pin A level
   output logic SIDE_PIN_A_OE, // Pin A drive enable
   output logic SIDE_PIN_B_O, // Pin B level
   output logic SIDE_PIN_B_OE, // Pin B drive enable
   output logic SIDE_PIN_C_O, // Pin C level
   output logic SIDE_PIN_C_OE // Pin C drive enable
);
   // ********************************
   // Input synchronisation
   // ********************************
   localparam int NLIVE = 8;
   logic [NLIVE-1:0] raw_in;
   logic [NLIVE-1:0] sync_in;
   logic [7:0] avg_sync;
   assign raw_in = {MOTOR_SHORT_LIVE, OBJECT_NEAR_RAW, CALIBRATION_BUSY, SAMPLING_ACTIVE_FLAG,
                    PRESENCE_SAMPLE_KIND, STYLUS_DOWN_LIVE, HEAT_WARNING_LIVE, HEAT_ALARM_LIVE};

   isu_sync #(.WIDTH(NLIVE)) u_sync (
      .clk(REF_CLK),
      .rst_n(RESETN),
      .ce(CE),
      .d(raw_in),
      .q(sync_in)
   );

   // Average may tear across bits; it is only sampled, never decoded
   isu_sync #(.WIDTH(8)) u_sync_avg (
      .clk(REF_CLK),
      .rst_n(RESETN),
      .ce(CE),
      .d(PRESENCE_AVERAGE_RAW),
      .q(avg_sync)
   );

   logic s_short, s_near, s_cal, s_conv, s_kind, s_pen, s_warn, s_alarm;
   assign {s_short, s_near, s_cal, s_conv, s_kind, s_pen, s_warn, s_alarm} = sync_in;

   // ********************************
   // Register state
   // ********************************
   logic [7:0] irq_mask, next_irq_mask;
   logic [7:0] irq_event_flags, next_irq_event_flags;
   logic [7:0] aux_pin_output_config, next_aux_pin_output_config;
   logic [7:0] aux_pin_output_selects, next_aux_pin_output_selects;
   logic reset_occurred_flag, next_reset_occurred_flag;
   logic cal_request_pending, next_cal_request_pending;
   logic object_near_live, next_object_near_live;
   logic [7:0] next_avg;
   logic [7:0] prev_live, next_prev_live;
   logic last_conv_prox, next_last_conv_prox;
   logic [7:0] next_rdata;
   logic next_irq, next_cal_req, next_soft_reset;
   logic [7:0] live_condition_flags;
   logic [7:0] event_hits;
   logic soft_reset;

   // Key write restores defaults the cycle after
   assign soft_reset = REG_WR && (REG_ADDR == isu_pkg::ADDR_RESET_KEY)
                       && (REG_WDATA == isu_pkg::RESET_KEY_VALUE);

   function automatic logic wr_hit(input logic [7:0] a);
      wr_hit = REG_WR && (REG_ADDR == a);
   endfunction

   function automatic logic rd_hit(input logic [7:0] a);
      rd_hit = REG_RD && (REG_ADDR == a);
   endfunction

   // ********************************
   // Live flags and edge detection
   // ********************************
   always_comb begin
      live_condition_flags = isu_pkg::ZERO_BYTE;
      live_condition_flags[isu_pkg::BIT_SHORT] = s_short;
      live_condition_flags[isu_pkg::BIT_RESET_SEEN] = reset_occurred_flag;
      live_condition_flags[isu_pkg::BIT_PRESENCE] = object_near_live;
      live_condition_flags[isu_pkg::BIT_CAL] = s_cal || cal_request_pending;
      live_condition_flags[isu_pkg::BIT_SAMPLING] = s_conv;
      live_condition_flags[isu_pkg::BIT_STYLUS_UP] = s_pen;
      live_condition_flags[isu_pkg::BIT_WARN] = s_warn;
      live_condition_flags[isu_pkg::BIT_ALARM] = s_alarm;
   end

   // Edges are taken from the previous live image, so events follow the reported bits
   always_comb begin
      logic rise_near, fall_near, conv_end;
      rise_near = live_condition_flags[isu_pkg::BIT_PRESENCE] && !prev_live[isu_pkg::BIT_PRESENCE];
      fall_near = !live_condition_flags[isu_pkg::BIT_PRESENCE] && prev_live[isu_pkg::BIT_PRESENCE];
      conv_end = !s_conv && prev_live[isu_pkg::BIT_SAMPLING];
      event_hits = isu_pkg::ZERO_BYTE;
      event_hits[isu_pkg::BIT_SHORT] = s_short && !prev_live[isu_pkg::BIT_SHORT];
      event_hits[isu_pkg::BIT_NEAR] = rise_near;
      event_hits[isu_pkg::BIT_PRESENCE] = PRESENCE_EVENT_CHOICE ? (conv_end && last_conv_prox)
                                          : fall_near;
      event_hits[isu_pkg::BIT_CAL] = !live_condition_flags[isu_pkg::BIT_CAL]
                                     && prev_live[isu_pkg::BIT_CAL];
      event_hits[isu_pkg::BIT_STYLUS_DOWN] = STYLUS_DETECT_MODE
                                             ? (s_pen && !prev_live[isu_pkg::BIT_STYLUS_UP])
                                             : (conv_end && !last_conv_prox);
      event_hits[isu_pkg::BIT_STYLUS_UP] = !s_pen && prev_live[isu_pkg::BIT_STYLUS_UP];
      event_hits[isu_pkg::BIT_WARN] = HEAT_WARNING_EDGE_CHOICE
                                      ? (!s_warn && prev_live[isu_pkg::BIT_WARN])
                                      : (s_warn && !prev_live[isu_pkg::BIT_WARN]);
      event_hits[isu_pkg::BIT_ALARM] = HEAT_ALARM_EDGE_CHOICE
                                       ? (!s_alarm && prev_live[isu_pkg::BIT_ALARM])
                                       : (s_alarm && !prev_live[isu_pkg::BIT_ALARM]);
   end

   // ********************************
   // Next-state of registers
   // ********************************
   always_comb begin
      next_irq_mask = irq_mask;
      next_irq_event_flags = irq_event_flags;
      next_aux_pin_output_config = aux_pin_output_config;
      next_aux_pin_output_selects = aux_pin_output_selects;
      next_reset_occurred_flag = reset_occurred_flag;
      next_cal_request_pending = cal_request_pending;
      next_object_near_live = object_near_live;
      next_avg = PRESENCE_AVERAGE_VALUE;
      next_prev_live = prev_live;
      next_last_conv_prox = last_conv_prox;
      next_rdata = REG_RDATA;
      next_irq = IRQ;
      next_cal_req = CALIBRATION_REQUEST;
      next_soft_reset = SOFT_RESET_PULSE;
      if (CE) begin
         next_prev_live = live_condition_flags;
         if (s_conv) begin
            next_last_conv_prox = s_kind;
         end
         // Hold proximity and its average while the pen is down
         if (!s_pen) begin
            next_object_near_live = s_near;
            next_avg = avg_sync;
         end
         // Request stays pending until the sequencer reports it busy
         if (s_cal) begin
            next_cal_request_pending = 1'b0;
         end
         next_cal_req = 1'b0;
         if (wr_hit(isu_pkg::ADDR_LIVE_FLAGS) && REG_WDATA[isu_pkg::BIT_CAL]) begin
            next_cal_request_pending = 1'b1;
            next_cal_req = 1'b1;
         end
         if (wr_hit(isu_pkg::ADDR_IRQ_MASK)) next_irq_mask = REG_WDATA;
         if (wr_hit(isu_pkg::ADDR_AUX_CONFIG)) next_aux_pin_output_config = REG_WDATA;
         if (wr_hit(isu_pkg::ADDR_AUX_SELECTS)) next_aux_pin_output_selects = REG_WDATA;
         // Read clears, but an event in the same cycle survives
         if (rd_hit(isu_pkg::ADDR_EVENT_FLAGS)) begin
            next_irq_event_flags = event_hits;
         end else begin
            next_irq_event_flags = irq_event_flags | event_hits;
         end
         if (rd_hit(isu_pkg::ADDR_LIVE_FLAGS)) next_reset_occurred_flag = 1'b0;
         unique case (REG_ADDR)
            isu_pkg::ADDR_IRQ_MASK: next_rdata = irq_mask;
            isu_pkg::ADDR_EVENT_FLAGS: next_rdata = irq_event_flags;
            isu_pkg::ADDR_LIVE_FLAGS: next_rdata = live_condition_flags;
            isu_pkg::ADDR_AUX_CONFIG: next_rdata = aux_pin_output_config;
            isu_pkg::ADDR_AUX_SELECTS: next_rdata = aux_pin_output_selects;
            default: next_rdata = isu_pkg::ZERO_BYTE;
         endcase
         if (!REG_RD) next_rdata = REG_RDATA;
         next_irq = |(next_irq_event_flags & next_irq_mask);
         next_soft_reset = soft_reset;
         if (soft_reset) begin
            next_irq_mask = isu_pkg::IRQ_MASK_RESET;
            next_irq_event_flags = isu_pkg::ZERO_BYTE;
            next_aux_pin_output_config = isu_pkg::ZERO_BYTE;
            next_aux_pin_output_selects = isu_pkg::ZERO_BYTE;
            next_cal_request_pending = 1'b0;
            next_cal_req = 1'b0;
            next_reset_occurred_flag = 1'b1;
            next_irq = 1'b0;
         end
      end
   end

   // Reset flag starts at one: power-up is itself a reset
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         irq_mask <= isu_pkg::IRQ_MASK_RESET;
         irq_event_flags <= isu_pkg::ZERO_BYTE;
         aux_pin_output_config <= isu_pkg::ZERO_BYTE;
         aux_pin_output_selects <= isu_pkg::ZERO_BYTE;
         reset_occurred_flag <= 1'b1;
         cal_request_pending <= 1'b0;
         object_near_live <= 1'b0;
         PRESENCE_AVERAGE_VALUE <= isu_pkg::ZERO_BYTE;
         prev_live <= isu_pkg::ZERO_BYTE;
         last_conv_prox <= 1'b0;
         REG_RDATA <= isu_pkg::ZERO_BYTE;
         IRQ <= 1'b0;
         CALIBRATION_REQUEST <= 1'b0;
         SOFT_RESET_PULSE <= 1'b0;
      end else begin
         irq_mask <= next_irq_mask;
         irq_event_flags <= next_irq_event_flags;
         aux_pin_output_config <= next_aux_pin_output_config;
         aux_pin_output_selects <= next_aux_pin_output_selects;
         reset_occurred_flag <= next_reset_occurred_flag;
         cal_request_pending <= next_cal_request_pending;
         object_near_live <= next_object_near_live;
         PRESENCE_AVERAGE_VALUE <= next_avg;
         prev_live <= next_prev_live;
         last_conv_prox <= next_last_conv_prox;
         REG_RDATA <= next_rdata;
         IRQ <= next_irq;
         CALIBRATION_REQUEST <= next_cal_req;
         SOFT_RESET_PULSE <= next_soft_reset;
      end
   end

   // ********************************
   // Side pins
   // ********************************
   logic block_a, block_b, block_c;
   assign block_a = PANEL_WIRING_TYPE || (PRESENCE_SENSOR_HOOKUP == isu_pkg::HOOKUP_SIDE_A);
   assign block_b = (PRESENCE_SENSOR_HOOKUP == isu_pkg::HOOKUP_SIDE_B);
   assign block_c = PANEL_WIRING_TYPE || (PRESENCE_SHIELD_HOOKUP == isu_pkg::HOOKUP_SIDE_C);

   isu_pin_mux u_pin_a (
      .clk(REF_CLK), .rst_n(RESETN), .ce(CE),
      .sel(aux_pin_output_config[3:0]),
      .events(irq_event_flags), .live(live_condition_flags),
      .drive_en(aux_pin_output_config[isu_pkg::EN_PIN_A]), .blocked(block_a),
      .pin_o(SIDE_PIN_A_O), .pin_oe(SIDE_PIN_A_OE)
   );

   isu_pin_mux u_pin_b (
      .clk(REF_CLK), .rst_n(RESETN), .ce(CE),
      .sel(aux_pin_output_selects[7:4]),
      .events(irq_event_flags), .live(live_condition_flags),
      .drive_en(aux_pin_output_config[isu_pkg::EN_PIN_B]), .blocked(block_b),
      .pin_o(SIDE_PIN_B_O), .pin_oe(SIDE_PIN_B_OE)
   );

   isu_pin_mux u_pin_c (
      .clk(REF_CLK), .rst_n(RESETN), .ce(CE),
      .sel(aux_pin_output_selects[3:0]),
      .events(irq_event_flags), .live(live_condition_flags),
      .drive_en(aux_pin_output_config[isu_pkg::EN_PIN_C]), .blocked(block_c),
      .pin_o(SIDE_PIN_C_O), .pin_oe(SIDE_PIN_C_OE)
   );

   // ********************************
   // Checks
   // ********************************
   AST_SHORT_EVENT: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      CE && event_hits[isu_pkg::BIT_SHORT] && !soft_reset |=> irq_event_flags[isu_pkg::BIT_SHORT])
      else $error("short event not latched");
   AST_NEAR_EVENT: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      CE && !soft_reset && $rose(object_near_live) |=> irq_event_flags[isu_pkg::BIT_NEAR])
      else $error("near event not latched");
   AST_STYLUS_UP: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      CE && !soft_reset && !s_pen && prev_live[isu_pkg::BIT_STYLUS_UP]
      |=> irq_event_flags[isu_pkg::BIT_STYLUS_UP])
      else $error("stylus up event lost");
   AST_RESET_FLAG_CLEAR: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      CE && REG_RD && REG_ADDR == isu_pkg::ADDR_LIVE_FLAGS && !soft_reset |=> !reset_occurred_flag)
      else $error("reset flag not cleared by read");
   AST_CAL_REQUEST: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      CE && REG_WR && REG_ADDR == isu_pkg::ADDR_LIVE_FLAGS && REG_WDATA[isu_pkg::BIT_CAL] && !soft_reset
      |=> CALIBRATION_REQUEST && live_condition_flags[isu_pkg::BIT_CAL])
      else $error("calibration request not raised");
   AST_MASK_WRITE: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      CE && REG_WR && REG_ADDR == isu_pkg::ADDR_IRQ_MASK && !soft_reset |=> irq_mask == $past(REG_WDATA))
      else $error("mask write not taken");
   AST_FREEZE: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      CE && s_pen |=> $stable(object_near_live))
      else $error("proximity changed with pen down");
   AST_IRQ: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      CE |=> IRQ == |(irq_event_flags & irq_mask))
      else $error("irq does not match enabled flags");
   AST_READ_CLEAR: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      CE && REG_RD && REG_ADDR == isu_pkg::ADDR_EVENT_FLAGS && event_hits == isu_pkg::ZERO_BYTE
      |=> irq_event_flags == isu_pkg::ZERO_BYTE)
      else $error("event flags not cleared by read");
   // Latched events may only drop through a read or a key reset
   AST_EVENT_HOLD: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      CE && !soft_reset && !(REG_RD && REG_ADDR == isu_pkg::ADDR_EVENT_FLAGS)
      |=> (irq_event_flags & $past(irq_event_flags)) == $past(irq_event_flags))
      else $error("event flag lost without read");
   AST_SOFT_RESET: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      CE && soft_reset |=> irq_mask == isu_pkg::IRQ_MASK_RESET && irq_event_flags == isu_pkg::ZERO_BYTE
      && reset_occurred_flag && SOFT_RESET_PULSE)
      else $error("key write did not restore defaults");
   AST_SOFT_PULSE: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      CE && soft_reset ##1 CE && !soft_reset |=> !SOFT_RESET_PULSE)
      else $error("reset pulse longer than one cycle");
endmodule

/* isu_host.sv */
// Host-side register master for the interrupt status unit.
// Assumes one-cycle strobes taken on REF_CLK, read data one cycle later.
`timescale 1ns/1ps
module isu_host (
   input wire logic clk, // System clock
   input wire logic [7:0] rdata, // Read data from device
   output logic [7:0] addr, // Register address
   output logic [7:0] wdata, // Write data
   output logic wr, // Write strobe
   output logic rd // Read strobe
);
   // Idle bus; address and data are scrambled once released so stale values never help
   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end
   // Single byte write, strobe held for exactly one taking edge
   task automatic write(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      #1;
      addr = a;
      wdata = v;
      wr = 1'b1;
      @(posedge clk);
      #1;
      wr = 1'b0;
      addr = ~a;
      wdata = ~v;
   endtask
   // Single byte read, data taken one cycle after the strobe edge
   task automatic read(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      #1;
      addr = a;
      rd = 1'b1;
      @(posedge clk);
      #1;
      rd = 1'b0;
      addr = ~a;
      @(posedge clk);
      #1;
      v = rdata;
   endtask
endmodule

/* tb_top.sv */
// Self-checking bench: event latching, live flags, side pins and keyed reset.
// Assumes the host model drives the register port and the bench drives sensing levels.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] sn = 8'h00; // Sense: short,near,cal,samp,kind,stylus,warn,alarm
   logic pch = 1'b0, wch = 1'b0, ach = 1'b1, det = 1'b1, wty = 1'b0;
   logic [3:0] sh = 4'h0, dh = 4'h0;
   logic [7:0] addr, wdata, rdata, d, avg;
   logic [7:0] praw = 8'h5a; // Raw proximity average
   logic wr, rd, irq, srst, seen, cal;
   wire [5:0] pin; // A_O,A_OE,B_O,B_OE,C_O,C_OE
   int error_cnt = 0;
   int checks_done = 0;
   // ********************************
   // Clock, reset, instances
   // ********************************
   initial forever #4 clk = ~clk;
   isu_host host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
   isu_top uut (.REF_CLK(clk), .RESETN(rst_n), .CE(1'b1), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .MOTOR_SHORT_LIVE(sn[7]), .OBJECT_NEAR_RAW(sn[6]),
      .PRESENCE_AVERAGE_RAW(praw), .CALIBRATION_BUSY(sn[5]), .SAMPLING_ACTIVE_FLAG(sn[4]),
      .PRESENCE_SAMPLE_KIND(sn[3]), .STYLUS_DOWN_LIVE(sn[2]), .HEAT_WARNING_LIVE(sn[1]),
      .HEAT_ALARM_LIVE(sn[0]), .PRESENCE_EVENT_CHOICE(pch), .HEAT_WARNING_EDGE_CHOICE(wch),
      .HEAT_ALARM_EDGE_CHOICE(ach), .STYLUS_DETECT_MODE(det), .PANEL_WIRING_TYPE(wty),
      .PRESENCE_SENSOR_HOOKUP(dh), .PRESENCE_SHIELD_HOOKUP(sh), .IRQ(irq), .CALIBRATION_REQUEST(cal),
      .SOFT_RESET_PULSE(srst), .PRESENCE_AVERAGE_VALUE(avg), .SIDE_PIN_A_O(pin[5]),
      .SIDE_PIN_A_OE(pin[4]), .SIDE_PIN_B_O(pin[3]), .SIDE_PIN_B_OE(pin[2]), .SIDE_PIN_C_O(pin[1]),
      .SIDE_PIN_C_OE(pin[0]));
   // ********************************
   // Shared helpers
   // ********************************
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
      host.read(a, d);
      `CHK(d, e)
   endtask
   // Change sense levels, wait past sync and edge detect, then read events
   task automatic sense(input logic [7:0] v, input logic [7:0] e);
      sn = v;
      settle(6);
      expect_reg(isu_pkg::ADDR_EVENT_FLAGS, e);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ********************************
   // Scenarios
   // ********************************
   task automatic test_reset();
      expect_reg(isu_pkg::ADDR_IRQ_MASK, 8'h08);
      expect_reg(isu_pkg::ADDR_LIVE_FLAGS, 8'h40);
      expect_reg(isu_pkg::ADDR_LIVE_FLAGS, 8'h00);
      expect_reg(8'h30, 8'h00);
      `CHK(avg, 8'h5a)
      $display("test reset done");
   endtask
   task automatic test_events();
      sense(8'h80, 8'h80);
      expect_reg(isu_pkg::ADDR_LIVE_FLAGS, 8'h80);
      `CHK(irq, 1'b0)
      sn = 8'h04;
      settle(5);
      `CHK(irq, 1'b1)
      sense(8'h04, 8'h08);
      // Near and average move while the pen is down: both must stay frozen
      praw = 8'h33;
      sense(8'h44, 8'h00);
      `CHK(avg, 8'h5a)
      settle(2);
      `CHK(irq, 1'b0)
      expect_reg(isu_pkg::ADDR_LIVE_FLAGS, 8'h04);
      sense(8'h00, 8'h04);
      `CHK(avg, 8'h33)
      sense(8'h40, 8'h40);
      expect_reg(isu_pkg::ADDR_LIVE_FLAGS, 8'h20);
      sense(8'h00, 8'h20);
      pch = 1'b1;
      sense(8'h18, 8'h00);
      expect_reg(isu_pkg::ADDR_LIVE_FLAGS, 8'h08);
      sense(8'h00, 8'h20);
      det = 1'b0;
      sense(8'h10, 8'h00);
      sense(8'h00, 8'h08);
      host.write(isu_pkg::ADDR_LIVE_FLAGS, 8'h10);
      `CHK(cal, 1'b1)
      expect_reg(isu_pkg::ADDR_LIVE_FLAGS, 8'h10);
      `CHK(cal, 1'b0)
      sense(8'h20, 8'h00);
      sense(8'h00, 8'h10);
      sense(8'h03, 8'h02);
      expect_reg(isu_pkg::ADDR_LIVE_FLAGS, 8'h03);
      sense(8'h00, 8'h01);
      $display("test events done");
   endtask
   task automatic test_pins();
      host.write(isu_pkg::ADDR_AUX_CONFIG, 8'h78);
      host.write(isu_pkg::ADDR_AUX_SELECTS, 8'h97);
      sn = 8'h81;
      settle(8);
      `CHK(pin, 6'b110111)
      wty = 1'b1;
      dh = 4'h2;
      settle(3);
      `CHK(pin & 6'b010101, 6'b000000)
      wty = 1'b0;
      dh = 4'h1;
      sh = 4'h3;
      settle(3);
      `CHK(pin & 6'b010101, 6'b000100)
      $display("test pins done");
   endtask
   task automatic test_soft();
      ach = 1'b0;
      sense(8'h00, 8'h80);
      host.write(isu_pkg::ADDR_IRQ_MASK, 8'hff);
      host.write(isu_pkg::ADDR_RESET_KEY, isu_pkg::RESET_KEY_VALUE);
      seen = srst;
      for (int i = 0; i < 4 && seen !== 1'b1; i++) begin
         settle(1);
         seen = srst;
      end
      `CHK(seen, 1'b1)
      expect_reg(isu_pkg::ADDR_IRQ_MASK, 8'h08);
      expect_reg(isu_pkg::ADDR_AUX_CONFIG, 8'h00);
      expect_reg(isu_pkg::ADDR_LIVE_FLAGS, 8'h40);
      `CHK(pin & 6'b010101, 6'b000000)
      $display("test soft reset done");
   endtask
   // Main sequence; watchdog bounds the whole run
   initial begin
      repeat (12) @(posedge clk);
      #1;
      rst_n = 1'b1;
      test_reset();
      test_events();
      test_pins();
      test_soft();
      summarize();
   end
   initial begin
      #400000;
      error_cnt++;
      summarize();
   end
endmodule
